// ==== design/apc_pkg.sv ====
// constants shared by the pin control block and its leaf cells
package apc_pkg;
	// port register field positions
	localparam int unsigned PORT_BIT_ZERO_VAL = 7;
	localparam int unsigned PORT_BIT_ONE_VAL = 6;
	localparam int unsigned PORT_BIT_ZERO_DIR = 5;
	localparam int unsigned PORT_BIT_ONE_DIR = 4;
	localparam int unsigned PORT_BIT_READY_ANY = 3;
	localparam int unsigned PORT_BIT_SYNC = 0;
	// writable bits of the port register, the rest read as zero
	localparam logic [7:0] PORT_WR_MASK = 8'hf9;
	// port register value after reset: both pins inputs, sync off
	localparam logic [7:0] PORT_RST = 8'h30;
	// serial frame length in bits
	localparam int unsigned FRAME_BITS = 8;
	localparam logic [2:0] FRAME_LAST = 3'h7;
	localparam logic [2:0] BIT_CNT_RST = 3'h0;
	// byte values after reset
	localparam logic [7:0] BYTE_RST = 8'h00;
	// serial state machine
	typedef enum logic [1:0] {
		SER_IDLE,
		SER_SHIFT,
		SER_DONE
	} apc_ser_state_t;
endpackage

// ==== design/apc_sync3.sv ====
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module apc_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	import apc_pkg::*;

	logic meta_r; // first stage, read only by the second
	logic s2_r; // second stage
	logic s3_r; // third stage

	// shift chain
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			meta_r <= async_in;
			s2_r <= meta_r;
			s3_r <= s2_r;
		end
	end

	// output moves only when stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_out <= RST_VAL;
		end else if (s2_r == s3_r) begin
			sync_out <= s3_r;
		end
	end
endmodule

// ==== design/apc_pin_cell.sv ====
// one general-purpose port pin: direction, drive and readback
`timescale 1ns/1ps
module apc_pin_cell (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dir_in, // 1 = input, 0 = driven output
	input wire logic val_bit, // stored value bit
	input wire logic pad_in, // pad level from outside
	output logic pad_out,
	output logic pad_oe_n, // low while the pin is driven
	output logic pad_sync, // filtered pad level
	output logic read_val // value bit as seen by a read
);
	import apc_pkg::*;

	// pad level brought into the core domain
	apc_sync3 #(
		.RST_VAL(1'b0)
	) u_pad_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(pad_in),
		.sync_out(pad_sync)
	);

	// drive registers: output drives stored bit, input floats
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out <= 1'b0;
			pad_oe_n <= 1'b1;
		end else begin
			pad_out <= val_bit; // R13
			pad_oe_n <= dir_in; // R8
		end
	end

	// readback: input pins return the sampled pad
	always_comb begin
		read_val = dir_in ? pad_sync : val_bit; // R13
	end
endmodule

// ==== design/apc_pin_ctrl.sv ====
// digital pin control: serial port pins, reset, master clock out, port pins
//
// Notes on behaviour
// R1 - host supplies serial clock, clocks all data
// R2 - chip select low held means 3-wire mode
// R3 - device answers serial traffic only when selected
// R4 - chip select can frame each 8-bit transfer
// R5 - reset returns all logic to power-on state
// R6 - clock output keeps running during reset
// R7 - clock output inverts input, can be disabled
// R8 - pin zero direction follows its direction bit
// R9 - pin zero value read and written via bit
// R10 - pin one direction follows its direction bit
// R11 - pin one value read and written via bit
// R12 - sync bit set makes pin one sync input
// R13 - output drives value bit, input reads pad
`timescale 1ns/1ps
module apc_pin_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	// serial host port
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic din_pin,
	output logic dout_pin,
	output logic dout_oe_n,
	// byte side of the serial port
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic frame_active,
	// master clock
	input wire logic master_clock_in,
	input wire logic master_clock_out_off,
	output logic master_clock_out,
	// port register access
	input wire logic port_wr,
	input wire logic [7:0] port_wdata,
	output logic [7:0] port_rdata,
	output logic ready_any_mode,
	// general-purpose pins
	input wire logic port_pin_zero_in,
	output logic port_pin_zero_out,
	output logic port_pin_zero_oe_n,
	input wire logic sync_or_port_pin_one_in,
	output logic sync_or_port_pin_one_out,
	output logic sync_or_port_pin_one_oe_n,
	// synchronisation to modulator and filter
	output logic filter_sync_pulse,
	output logic filter_hold
);
	import apc_pkg::*;

	// synchronised serial inputs
	logic sclk_s; // filtered serial clock
	logic cs_n_s; // filtered chip select
	logic din_s; // filtered serial data
	logic sclk_d_r; // previous serial clock level
	logic sclk_rise; // serial clock rising edge
	logic sclk_fall; // serial clock falling edge
	logic selected; // device addressed by host

	// serial engine state
	apc_ser_state_t ser_state_r;
	apc_ser_state_t ser_state_nxt;
	logic [2:0] bit_cnt_r; // bits taken in this frame
	logic [7:0] rx_shift_r; // incoming shift register
	logic [7:0] tx_shift_r; // outgoing shift register

	// port register and pin views
	logic [7:0] port_r; // stored port register
	logic pin_zero_direction; // 1 = input
	logic pin_one_direction; // 1 = input
	logic sync_enable; // pin one used as sync
	logic pin_one_dir_eff; // direction after sync override
	logic pin_zero_read; // pin zero readback
	logic pin_one_read; // pin one readback
	logic pin_one_level; // pin one pad level
	logic pin_one_level_d_r; // previous pin one level for edges

	// host clock, select and data into core domain
	apc_sync3 #(
		.RST_VAL(1'b0)
	) u_sclk_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(sclk_pin),
		.sync_out(sclk_s)
	);

	// chip select idles high (deselected)
	apc_sync3 #(
		.RST_VAL(1'b1)
	) u_cs_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(cs_n_pin),
		.sync_out(cs_n_s)
	);

	// serial data input
	apc_sync3 #(
		.RST_VAL(1'b0)
	) u_din_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(din_pin),
		.sync_out(din_s)
	);

	// edge finder on the host serial clock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end

	// all transfers timed by host clock edges only
	always_comb begin
		sclk_rise = sclk_s & ~sclk_d_r; // R1
		sclk_fall = ~sclk_s & sclk_d_r; // R1
		selected = ~cs_n_s; // R3
	end

	// serial state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state_r <= SER_IDLE; // R5
		end else begin
			ser_state_r <= ser_state_nxt;
		end
	end

	// serial next state: deselect always ends the frame
	always_comb begin
		ser_state_nxt = ser_state_r;
		case (ser_state_r)
			SER_IDLE: begin
				if (selected) begin
					ser_state_nxt = SER_SHIFT; // R2
				end
			end
			SER_SHIFT: begin
				if (!selected) begin
					ser_state_nxt = SER_IDLE; // R4
				end else if (sclk_rise && bit_cnt_r == FRAME_LAST) begin
					ser_state_nxt = SER_DONE;
				end
			end
			SER_DONE: begin
				// one cycle to hand the byte over, then next frame
				if (!selected) begin
					ser_state_nxt = SER_IDLE;
				end else begin
					ser_state_nxt = SER_SHIFT; // R2
				end
			end
			default: begin
				ser_state_nxt = SER_IDLE;
			end
		endcase
	end

	// bit counter, restarted whenever select drops away
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= BIT_CNT_RST;
		end else if (!selected) begin
			bit_cnt_r <= BIT_CNT_RST; // R4
		end else if (ser_state_r == SER_SHIFT && sclk_rise) begin
			bit_cnt_r <= bit_cnt_r + 3'h1; // wraps to zero after eight
		end
	end

	// receive shift, msb first, on host clock rising edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_shift_r <= BYTE_RST;
		end else if (selected && ser_state_r == SER_SHIFT && sclk_rise) begin
			rx_shift_r <= {rx_shift_r[6:0], din_s}; // R3
		end
	end

	// completed byte and its strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_byte <= BYTE_RST;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= (ser_state_r == SER_DONE); // R4
			if (ser_state_r == SER_DONE) begin
				rx_byte <= rx_shift_r;
			end
		end
	end

	// transmit shift: load at frame start, move on falling edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_shift_r <= BYTE_RST;
		end else if (ser_state_r == SER_IDLE || ser_state_r == SER_DONE) begin
			tx_shift_r <= tx_byte; // R4
		end else if (selected && sclk_fall && bit_cnt_r != BIT_CNT_RST) begin
			tx_shift_r <= {tx_shift_r[6:0], 1'b0}; // R1
		end
	end

	// data out pin released while deselected
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_pin <= 1'b0;
			dout_oe_n <= 1'b1;
		end else begin
			dout_pin <= tx_shift_r[7];
			dout_oe_n <= ~selected; // R3
		end
	end

	// frame indicator for the byte side
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_active <= 1'b0;
		end else begin
			frame_active <= (ser_state_r != SER_IDLE); // R4
		end
	end

	// inverted master clock, untouched by reset, can be switched off
	always_comb begin
		master_clock_out = ~master_clock_in & ~master_clock_out_off; // R6 R7
	end

	// port register write, reserved bits held at zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_r <= PORT_RST; // R5
		end else if (port_wr) begin
			port_r <= port_wdata & PORT_WR_MASK; // R9 R11
		end
	end

	// field views of the port register
	always_comb begin
		pin_zero_direction = port_r[PORT_BIT_ZERO_DIR]; // R8
		pin_one_direction = port_r[PORT_BIT_ONE_DIR]; // R10
		sync_enable = port_r[PORT_BIT_SYNC]; // R12
		pin_one_dir_eff = pin_one_direction | sync_enable; // R12
		ready_any_mode = port_r[PORT_BIT_READY_ANY];
	end

	// pin zero cell
	apc_pin_cell u_pin_zero (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.dir_in(pin_zero_direction),
		.val_bit(port_r[PORT_BIT_ZERO_VAL]),
		.pad_in(port_pin_zero_in),
		.pad_out(port_pin_zero_out),
		.pad_oe_n(port_pin_zero_oe_n),
		.pad_sync(),
		.read_val(pin_zero_read)
	);

	// pin one cell, forced to input while sync is on
	apc_pin_cell u_pin_one (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.dir_in(pin_one_dir_eff),
		.val_bit(port_r[PORT_BIT_ONE_VAL]),
		.pad_in(sync_or_port_pin_one_in),
		.pad_out(sync_or_port_pin_one_out),
		.pad_oe_n(sync_or_port_pin_one_oe_n),
		.pad_sync(pin_one_level),
		.read_val(pin_one_read)
	);

	// port register read with live pin values
	always_comb begin
		port_rdata = port_r;
		port_rdata[PORT_BIT_ZERO_VAL] = pin_zero_read; // R9
		port_rdata[PORT_BIT_ONE_VAL] = pin_one_read; // R11
	end

	// previous pin one level for sync edge finding
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_one_level_d_r <= 1'b1;
		end else begin
			pin_one_level_d_r <= pin_one_level;
		end
	end

	// sync: low level holds filter, falling edge restarts it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_sync_pulse <= 1'b0;
			filter_hold <= 1'b0;
		end else begin
			filter_sync_pulse <= sync_enable & pin_one_level_d_r & ~pin_one_level; // R12
			filter_hold <= sync_enable & ~pin_one_level; // R12
		end
	end
endmodule

// ==== verif/apc_pin_ctrl_props.sv ====
// concurrent checks on the pin control block ports
`timescale 1ns/1ps
module apc_pin_ctrl_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic dout_oe_n,
	input wire logic rx_valid,
	input wire logic master_clock_in,
	input wire logic master_clock_out_off,
	input wire logic master_clock_out,
	input wire logic port_wr,
	input wire logic [7:0] port_wdata,
	input wire logic [7:0] port_rdata,
	input wire logic port_pin_zero_out,
	input wire logic port_pin_zero_oe_n,
	input wire logic sync_or_port_pin_one_out,
	input wire logic sync_or_port_pin_one_oe_n,
	input wire logic filter_sync_pulse
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// a write then a quiet cycle: pin outputs settle one edge later
	sequence s_zero_out; port_wr && !port_wdata[5] ##1 !port_wr; endsequence
	sequence s_zero_in; port_wr && port_wdata[5] ##1 !port_wr; endsequence
	sequence s_one_out; port_wr && !port_wdata[4] && !port_wdata[0] ##1 !port_wr; endsequence
	sequence s_sync_on; port_wr && port_wdata[0] ##1 !port_wr; endsequence
	a_mclk_invert: assert property (master_clock_out == (!master_clock_in && !master_clock_out_off))
		else $error("clock output not inverted input");
	a_zero_drive: assert property (s_zero_out |=> !port_pin_zero_oe_n && port_pin_zero_out == $past(port_wdata[7], 2))
		else $error("pin zero not driving value");
	a_zero_input: assert property (s_zero_in |=> port_pin_zero_oe_n)
		else $error("pin zero driven as input");
	a_one_drive: assert property (s_one_out |=> !sync_or_port_pin_one_oe_n && sync_or_port_pin_one_out == $past(port_wdata[6], 2))
		else $error("pin one not driving value");
	a_sync_input: assert property (s_sync_on |=> sync_or_port_pin_one_oe_n)
		else $error("pin one driven with sync on");
	a_rdata_mask: assert property (port_wr |=> port_rdata[5:0] == ($past(port_wdata[5:0]) & 6'h39))
		else $error("port readback wrong");
	a_cs_release: assert property (cs_n_pin [*8] |-> dout_oe_n)
		else $error("data out driven while unselected");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("receive strobe too long");
	a_sync_pulse: assert property (filter_sync_pulse |=> !filter_sync_pulse)
		else $error("sync pulse too long");
endmodule
bind apc_pin_ctrl apc_pin_ctrl_props props (.core_clk, .rst_n, .cs_n_pin, .dout_oe_n, .rx_valid, .master_clock_in,
	.master_clock_out_off, .master_clock_out, .port_wr, .port_wdata, .port_rdata, .port_pin_zero_out,
	.port_pin_zero_oe_n, .sync_or_port_pin_one_out, .sync_or_port_pin_one_oe_n, .filter_sync_pulse);

// ==== verif/apc_host_model.sv ====
// host side of the serial port: makes sclk, frames with chip select
`timescale 1ns/1ps
module apc_host_model (
	output logic sclk_pin,
	output logic cs_n_pin,
	output logic din_pin,
	input wire logic dout_pin,
	input wire logic dout_oe_n
);
	logic [7:0] got; // byte read back, msb first
	initial begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
		din_pin = 1'b0;
	end
	// one frame; sel low keeps select high, hold leaves it low after
	task automatic xfer(input logic [7:0] tx, input logic sel, input logic hold);
		if (sel) begin
			cs_n_pin = 1'b0;
			#600;
		end
		for (int i = 7; i >= 0; i--) begin
			din_pin = tx[i];
			#400 sclk_pin = 1'b1;
			// read at the end of the high phase: the filtered output lags the pin
			#400 got[i] = dout_oe_n ? 1'bx : dout_pin;
			sclk_pin = 1'b0;
		end
		din_pin = ~din_pin; // no stale bit after the frame
		#600;
		if (!hold) begin
			cs_n_pin = 1'b1;
		end
	endtask
endmodule

// ==== verif/test_adc_digital_pin_control.sv ====
// self-checking bench for the pin control block
`timescale 1ns/1ps
module test_adc_digital_pin_control;
	import apc_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk_pin, cs_n_pin, din_pin, dout_pin, dout_oe_n, rx_valid, frame_active;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rx_byte, port_rdata;
	logic [7:0] port_wdata = 8'h00;
	logic master_clock_in = 1'b0;
	logic master_clock_out_off = 1'b0;
	logic port_wr = 1'b0;
	logic pad0 = 1'b1;
	logic pad1 = 1'b1;
	logic master_clock_out, ready_any_mode, filter_sync_pulse, filter_hold;
	logic port_pin_zero_in, port_pin_zero_out, port_pin_zero_oe_n;
	logic sync_or_port_pin_one_in, sync_or_port_pin_one_out, sync_or_port_pin_one_oe_n;
	int err_count = 0;
	int samples_checked = 0;
	int rx_cnt = 0;
	always #50 core_clk = ~core_clk;
	always @(negedge core_clk) master_clock_in <= ~master_clock_in;
	always @(posedge core_clk) if (rx_valid === 1'b1) rx_cnt++;
	// pad level: the driving side wins, else the bench
	assign port_pin_zero_in = port_pin_zero_oe_n ? pad0 : port_pin_zero_out;
	assign sync_or_port_pin_one_in = sync_or_port_pin_one_oe_n ? pad1 : sync_or_port_pin_one_out;
	apc_pin_ctrl dut (.core_clk, .rst_n, .sclk_pin, .cs_n_pin, .din_pin, .dout_pin, .dout_oe_n, .tx_byte,
		.rx_byte, .rx_valid, .frame_active, .master_clock_in, .master_clock_out_off, .master_clock_out,
		.port_wr, .port_wdata, .port_rdata, .ready_any_mode, .port_pin_zero_in, .port_pin_zero_out,
		.port_pin_zero_oe_n, .sync_or_port_pin_one_in, .sync_or_port_pin_one_out,
		.sync_or_port_pin_one_oe_n, .filter_sync_pulse, .filter_hold);
	apc_host_model host (.sclk_pin, .cs_n_pin, .din_pin, .dout_pin, .dout_oe_n);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] d);
		port_wr = 1'b1;
		port_wdata = d;
		tick(1);
		port_wr = 1'b0;
		tick(2);
	endtask
	// reset state, clock output alive while in reset
	task automatic t_reset;
		check(port_rdata, PORT_RST);
		check({port_pin_zero_oe_n, sync_or_port_pin_one_oe_n, dout_oe_n}, 8'h07);
		check({rx_valid, frame_active, filter_sync_pulse}, 8'h00);
		check(master_clock_out, {7'h00, ~master_clock_in});
	endtask
	task automatic t_mclk;
		for (int o = 0; o < 2; o++) begin
			master_clock_out_off = o[0];
			tick(1);
			check(master_clock_out, {7'h00, ~master_clock_in & ~o[0]});
			tick(1);
			check(master_clock_out, {7'h00, ~master_clock_in & ~o[0]});
		end
	endtask
	task automatic t_pins;
		for (int v = 0; v < 2; v++) begin
			wr({v[0], ~v[0], 6'h08});
			check({port_pin_zero_oe_n, sync_or_port_pin_one_oe_n}, 8'h00);
			check({port_pin_zero_out, sync_or_port_pin_one_out}, {v[0], ~v[0]});
			check(port_rdata, {v[0], ~v[0], 6'h08});
			check(ready_any_mode, 1'b1);
			pad0 = ~v[0];
			pad1 = v[0];
			wr(8'h36);
			tick(6);
			check({port_pin_zero_oe_n, sync_or_port_pin_one_oe_n}, 8'h03);
			check(port_rdata, {~v[0], v[0], 6'h30});
		end
	endtask
	task automatic t_sync;
		int n;
		wr(8'h01);
		check(sync_or_port_pin_one_oe_n, 1'b1);
		tick(6);
		pad1 = 1'b0;
		for (n = 0; n < 20 && filter_sync_pulse !== 1'b1; n++) tick(1);
		check(n < 20, 1'b1);
		tick(1);
		check({filter_sync_pulse, filter_hold}, 8'h01);
		pad1 = 1'b1;
		wr(PORT_RST);
	endtask
	task automatic t_serial;
		int c;
		tx_byte = 8'ha5;
		host.xfer(8'h3c, 1'b1, 1'b0);
		check(rx_byte, 8'h3c);
		check(host.got, 8'ha5);
		tx_byte = 8'h5a;
		tick(10);
		host.xfer(8'hc3, 1'b1, 1'b1);
		check(rx_byte, 8'hc3);
		check(frame_active, 1'b1);
		host.xfer(8'h81, 1'b1, 1'b0);
		check(rx_byte, 8'h81);
		check(host.got, 8'h5a);
		check(rx_cnt[7:0], 8'h03);
		tick(10);
		c = rx_cnt;
		host.xfer(8'hff, 1'b0, 1'b0);
		check(rx_cnt[7:0], c[7:0]);
		check(dout_oe_n, 1'b1);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		conclude();
	end
	initial begin
		tick(2);
		t_reset();
		tick(2);
		rst_n = 1'b1;
		tick(5);
		t_mclk();
		t_pins();
		t_sync();
		t_serial();
		wr(8'h80);
		rst_n = 1'b0;
		tick(1);
		t_reset();
		rst_n = 1'b1;
		tick(5);
		conclude();
	end
endmodule
